/* File: core/fcopt_regs.sv */
`timescale 1ns/10ps
module fcopt_regs import fcopt_pkg::*; (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] nonvolatileOptionByte,
	input wire logic [63:0] storedBackdoorKey,
	input wire logic debugAccess,
	input wire logic firmwareSecure,
	input wire logic blankCheckPass,
	output logic eraseProgramEnable,
	output logic timingPulse,
	output logic redirectEnable,
	output logic deviceSecure
);
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		return a == off;
	endfunction

	fcopt_div_t divReg;
	fcopt_opt_t optReg;
	logic inReset;
	logic [2:0] preCount;
	logic [5:0] divCount;
	logic preTick;
	logic keyAccess;
	fcopt_key_state_t keyState;
	logic [2:0] keyIndex;
	logic keyMatch;
	logic keyStart;
	logic [7:0] keyByte;
	logic access;
	logic wrEn;
	logic secure;

	assign access = psel && penable;
	assign wrEn = access && pwrite;
	assign keyByte = pwdata[7:0];
	// Only code 10 unsecures
	assign secure = optReg.securityCode != SEC_UNSECURED;

	////////////////////////////////////////////////////////////////////////////////
	// Divider register, write-once
	always_ff @(posedge clk) begin
		if (reset) begin
			divReg <= DIV_RESET;
		end else if (wrEn && hit(paddr, DIV_OFFSET) && !divReg.loaded) begin
			divReg.loaded <= 1'b1;
			divReg.prescale <= pwdata[PRESCALE_BIT];
			divReg.divisor <= pwdata[5:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			eraseProgramEnable <= 1'b0;
		end else begin
			eraseProgramEnable <= divReg.loaded;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler and divider; pulse stops until divisor loaded
	assign preTick = !divReg.prescale || preCount == PRESCALE_COUNT;

	always_ff @(posedge clk) begin
		if (reset || !divReg.loaded) begin
			preCount <= 3'h0;
		end else begin
			preCount <= preCount + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset || !divReg.loaded) begin
			divCount <= 6'h00;
			timingPulse <= 1'b0;
		end else begin
			timingPulse <= 1'b0;
			if (preTick) begin
				if (divCount >= divReg.divisor) begin
					divCount <= 6'h00;
					timingPulse <= 1'b1;
				end else begin
					divCount <= divCount + 6'h01;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Options copy: caught at release, writes ignored
	always_ff @(posedge clk) begin
		inReset <= reset;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			optReg <= '0;
		end else if (inReset) begin
			optReg <= nonvolatileOptionByte & OPT_USED_MASK;
		end else if (keyState == KEY_CHECK && keyMatch && optReg.backdoorEnable) begin
			optReg.securityCode <= SEC_UNSECURED;
		end else if (blankCheckPass) begin
			optReg.securityCode <= SEC_UNSECURED;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			redirectEnable <= 1'b0;
			deviceSecure <= 1'b1;
		end else begin
			redirectEnable <= !optReg.redirectDisable;
			deviceSecure <= secure;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Backdoor key entry; debug writes never start entry or enter key bytes, but a debug control write of 0 still aborts it
	assign keyStart = wrEn && hit(paddr, CTRL_OFFSET);

	always_ff @(posedge clk) begin
		if (reset) begin
			keyAccess <= 1'b0;
		end else if (keyStart) begin
			keyAccess <= pwdata[0] && firmwareSecure && !debugAccess;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			keyState <= KEY_IDLE;
			keyIndex <= 3'h0;
			keyMatch <= 1'b0;
		end else begin
			case (keyState)
				KEY_IDLE: begin
					keyIndex <= 3'h0;
					keyMatch <= 1'b1;
					if (keyStart && pwdata[0] && firmwareSecure && !debugAccess) begin
						keyState <= KEY_COLLECT;
					end
				end
				KEY_COLLECT: begin
					if (wrEn && hit(paddr, KEY_OFFSET) && !debugAccess && keyIndex <= KEY_LAST) begin
						// Lowest byte first
						if (keyByte != storedBackdoorKey[keyIndex*8 +: 8]) begin
							keyMatch <= 1'b0;
						end
						keyIndex <= keyIndex + 3'h1;
						if (keyIndex == KEY_LAST) begin
							keyState <= KEY_CHECK;
						end
					end else if (keyStart && !pwdata[0]) begin
						keyState <= KEY_IDLE; // Short key never matches
					end
				end
				KEY_CHECK: begin
					if (keyStart && !pwdata[0]) begin
						keyState <= KEY_IDLE;
					end
				end
				default: begin
					keyState <= KEY_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait; unmapped reads zero with error
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable) begin
				if (hit(paddr, DIV_OFFSET)) begin
					prdata <= {24'h000000, divReg};
				end else if (hit(paddr, OPT_OFFSET)) begin
					prdata <= {24'h000000, optReg};
				end else if (hit(paddr, KEY_OFFSET)) begin
					prdata <= 32'h0000_0000;
				end else if (hit(paddr, CTRL_OFFSET)) begin
					prdata <= {31'h00000000, keyAccess};
				end else if (hit(paddr, STAT_OFFSET)) begin
					prdata <= {29'h00000000, keyState == KEY_CHECK, eraseProgramEnable, secure};
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	property p_loaded_sticky;
		@(posedge clk) disable iff (reset) divReg.loaded |=> divReg.loaded;
	endproperty
	a_loaded_sticky: assert property (p_loaded_sticky)
		else $error("loaded flag fell");
	property p_second_write_ignored;
		@(posedge clk) disable iff (reset)
		(wrEn && hit(paddr, DIV_OFFSET) && divReg.loaded) |=> $stable(divReg);
	endproperty
	a_second_write_ignored: assert property (p_second_write_ignored)
		else $error("divider changed after first write");
	property p_first_write_loads;
		@(posedge clk) disable iff (reset)
		(wrEn && hit(paddr, DIV_OFFSET) && !divReg.loaded) |=> divReg.loaded &&
			divReg.divisor == $past(pwdata[5:0]);
	endproperty
	a_first_write_loads: assert property (p_first_write_loads)
		else $error("first divider write not taken");
	property p_no_op_unloaded;
		@(posedge clk) disable iff (reset) !divReg.loaded |=> !eraseProgramEnable;
	endproperty
	a_no_op_unloaded: assert property (p_no_op_unloaded)
		else $error("operations enabled before load");
	property p_pulse_spacing;
		@(posedge clk) disable iff (reset)
		(timingPulse && !divReg.prescale && divReg.divisor == 6'h01) |=> !timingPulse ##1 timingPulse;
	endproperty
	a_pulse_spacing: assert property (p_pulse_spacing)
		else $error("pulse period wrong");
	property p_unused_zero;
		@(posedge clk) disable iff (reset) optReg.unused == 4'h0;
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("unused option bits set");
	property p_opt_write_ignored;
		@(posedge clk) disable iff (reset)
		(wrEn && hit(paddr, OPT_OFFSET) && !inReset && !blankCheckPass && keyState != KEY_CHECK)
			|=> $stable(optReg);
	endproperty
	a_opt_write_ignored: assert property (p_opt_write_ignored)
		else $error("option register written");
	property p_no_backdoor;
		@(posedge clk) disable iff (reset)
		(!optReg.backdoorEnable && !blankCheckPass && secure && !inReset) |=> secure;
	endproperty
	a_no_backdoor: assert property (p_no_backdoor)
		else $error("unsecured without backdoor enable");
	property p_blank_unsecures;
		@(posedge clk) disable iff (reset)
		(blankCheckPass && !inReset) |=> !secure ##1 !deviceSecure;
	endproperty
	a_blank_unsecures: assert property (p_blank_unsecures)
		else $error("blank check did not unsecure");
	property p_debug_no_key;
		@(posedge clk) disable iff (reset) (keyStart && debugAccess) |=> !keyAccess;
	endproperty
	a_debug_no_key: assert property (p_debug_no_key)
		else $error("debug opened key access");
	c_load: cover property (@(posedge clk) disable iff (reset) $rose(divReg.loaded));
	c_pulse: cover property (@(posedge clk) disable iff (reset) timingPulse);
	c_key_unlock: cover property (@(posedge clk) disable iff (reset)
		keyState == KEY_CHECK && keyMatch && optReg.backdoorEnable);
endmodule

/* File: core/fcopt_pkg.sv */
package fcopt_pkg;
	localparam logic [11:0] DIV_OFFSET = 12'h000;
	localparam logic [11:0] OPT_OFFSET = 12'h004;
	localparam logic [11:0] KEY_OFFSET = 12'h008;
	localparam logic [11:0] CTRL_OFFSET = 12'h00C;
	localparam logic [11:0] STAT_OFFSET = 12'h010;
	localparam int LOADED_BIT = 7;
	localparam int PRESCALE_BIT = 6;
	localparam int BACKDOOR_ENABLE_BIT = 7;
	localparam int NORED_BIT = 6;
	localparam logic [7:0] DIV_RESET = 8'h00;
	localparam logic [7:0] OPT_USED_MASK = 8'hC3;
	localparam logic [1:0] SEC_UNSECURED = 2'h2;
	localparam logic [2:0] PRESCALE_COUNT = 3'h7;
	localparam logic [2:0] KEY_LAST = 3'h7;
	localparam int KEY_BYTES = 8;

	typedef struct packed {
		logic loaded;
		logic prescale;
		logic [5:0] divisor;
	} fcopt_div_t;

	typedef struct packed {
		logic backdoorEnable;
		logic redirectDisable;
		logic [3:0] unused;
		logic [1:0] securityCode;
	} fcopt_opt_t;

	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_COLLECT = 2'b01,
		KEY_CHECK = 2'b10
	} fcopt_key_state_t;
endpackage

/* File: sim/fcopt_nvm_model.sv */
`timescale 1ns/10ps
module fcopt_nvm_model import fcopt_pkg::*; #(
	parameter logic [63:0] KEY = 64'h0
) (
	input wire logic [1:0] profile,
	output logic [7:0] optionByte,
	output logic [63:0] keyBytes
);
	////////////////////////////////////////////////////////////////////////////
	// Lowest key location in bits 7:0
	assign keyBytes = KEY;
	// Unused bits programmed high so a leak shows on readback
	always_comb begin
		case (profile)
			2'h0: optionByte = 8'hFF;
			2'h1: optionByte = 8'h3D;
			default: optionByte = 8'h7E;
		endcase
	end
endmodule

/* File: sim/fcopt_regs_tb.sv */
`timescale 1ns/10ps
module fcopt_regs_tb import fcopt_pkg::*;;
	localparam logic [63:0] KEY_VAL = 64'h0123456789ABCDEF;
	logic clk = 1'b0;
	logic reset, psel, penable, pwrite, debugAccess, firmwareSecure, blankCheckPass;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic pready, pslverr, rerr, eraseProgramEnable, timingPulse, redirectEnable, deviceSecure;
	logic [1:0] profile;
	logic [7:0] optByte;
	logic [63:0] keyBytes;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;
	////////////////////////////////////////////////////////////////////////////
	always #12.5 clk = ~clk;
	fcopt_nvm_model #(.KEY(KEY_VAL)) u_nvm (.profile(profile), .optionByte(optByte),
		.keyBytes(keyBytes));
	fcopt_regs u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nonvolatileOptionByte(optByte), .storedBackdoorKey(keyBytes),
		.debugAccess(debugAccess), .firmwareSecure(firmwareSecure),
		.blankCheckPass(blankCheckPass), .eraseProgramEnable(eraseProgramEnable),
		.timingPulse(timingPulse), .redirectEnable(redirectEnable), .deviceSecure(deviceSecure));
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task results;
		if (bad_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// Hang guard, run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			results();
		end
	end
	task rst(input logic [1:0] p);
		@(posedge clk);
		reset <= 1'b1;
		profile <= p;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// Request held until pready seen high at a falling edge
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Answer is registered, so it is settled at the falling edge before the sampling edge
		do begin
			@(negedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
		end
		rdata = prdata;
		rerr = pslverr;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rdata, {24'h000000, exp});
	endtask
	////////////////////////////////////////////////////////////////////////////
	task opt_case(input logic [1:0] p, input logic [7:0] eo, input logic er, input logic es);
		rst(p);
		rd(OPT_OFFSET, eo);
		chk(redirectEnable, er);
		chk(deviceSecure, es);
		rd(DIV_OFFSET, 8'h00);
		chk(eraseProgramEnable, 1'b0);
		apb(1'b1, OPT_OFFSET, ~eo);
		rd(OPT_OFFSET, eo);
	endtask
	// Flag bit written as zero: it must still come back set
	task div_case(input logic [6:0] d, input int period);
		int n;
		apb(1'b1, DIV_OFFSET, {1'b0, d});
		rd(DIV_OFFSET, {1'b1, d});
		chk(eraseProgramEnable, 1'b1);
		apb(1'b1, DIV_OFFSET, {1'b1, ~d});
		rd(DIV_OFFSET, {1'b1, d});
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (timingPulse !== 1'b1 && n < 300);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (timingPulse !== 1'b1 && n < 300);
		chk(n, period);
	endtask
	task key_case(input logic dbg, input logic [63:0] k, input logic es);
		debugAccess <= dbg;
		firmwareSecure <= ~dbg;
		apb(1'b1, CTRL_OFFSET, 8'h01);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, KEY_OFFSET, k[8*i+:8]);
		end
		apb(1'b1, CTRL_OFFSET, 8'h00);
		repeat (3) @(posedge clk);
		chk(deviceSecure, es);
		debugAccess <= 1'b0;
		firmwareSecure <= 1'b0;
	endtask
	task blank_case;
		@(posedge clk);
		blankCheckPass <= 1'b1;
		@(posedge clk);
		blankCheckPass <= 1'b0;
		repeat (3) @(posedge clk);
		chk(deviceSecure, 1'b0);
		apb(1'b0, 12'h100, 8'h00);
		chk(rerr, 1'b1);
		chk(rdata, 32'h00000000);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, debugAccess, firmwareSecure, blankCheckPass} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		profile = 2'h0;
		opt_case(2'h0, 8'hC3, 1'b0, 1'b1);
		key_case(1'b1, KEY_VAL, 1'b1);
		key_case(1'b0, ~KEY_VAL, 1'b1);
		key_case(1'b0, KEY_VAL, 1'b0);
		div_case(7'h01, 2);
		opt_case(2'h1, 8'h01, 1'b1, 1'b1);
		key_case(1'b0, KEY_VAL, 1'b1);
		div_case(7'h41, 16);
		blank_case();
		opt_case(2'h2, 8'h42, 1'b0, 1'b0);
		div_case(7'h58, 200);
		results();
	end
endmodule
